// *** verilog/analog_input_linear_scaler.sv ***
// Purpose: scales demand, feedback and speed inputs for the position loop
// Assumes: raw samples are signed, 10000 = full scale on the voltage range
// Notes: one sample_valid scales all three inputs, result one cycle later
//
// How it works
// - two scaling modes exist and reset selects the simple one.
// - equation mode gives (input - offset) * numerator / denominator.
// - numerator and denominator are signed, clamped to +-10000, gain is their ratio.
// - the offset is signed in 0.01 % of full scale and removed before the gain.
// - each input picks voltage or current; current enables the sense resistor and rescales.
// - every input has its own coefficients and selection and is scaled on its own.
// - offset 2000 on a current input strips the 20 % live zero, and with gain 1250/1000 20 mA gives full output.
`timescale 1ns/100ps
module analog_input_linear_scaler
	import scaler_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [5:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic sample_valid,
	input wire logic signed [15:0] raw_demand,
	input wire logic signed [15:0] raw_feedback,
	input wire logic signed [15:0] raw_speed,
	output logic scaled_valid,
	output logic signed [15:0] scaled_demand,
	output logic signed [15:0] scaled_feedback,
	output logic signed [15:0] scaled_speed,
	output logic [2:0] current_sense_en
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		input_scaling_mode_e input_scaling_mode_select;
		logic [NCH-1:0][15:0] num;
		logic [NCH-1:0][15:0] den;
		logic [NCH-1:0][15:0] off;
		logic [NCH-1:0] sel;
		logic [NCH-1:0][15:0] scaled;
		logic valid;
		logic [31:0] rdata;
	} state_s;

	state_s q;
	state_s next_q;
	logic [NCH-1:0][15:0] raw;
	logic [NCH-1:0][15:0] result;
	logic [NCH-1:0][15:0] eval;

	assign raw[0] = raw_demand;
	assign raw[1] = raw_feedback;
	assign raw[2] = raw_speed;

	// saturate instead of wrapping so an overrange input pins at the rail
	function automatic logic [15:0] sat16(input logic signed [33:0] v);
		if (v > 34'sd32767)
		begin
			return 16'h7FFF;
		end
		if (v < -34'sd32768)
		begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction

	// coefficients out of range are clamped at write time
	function automatic logic [15:0] clamp_coef(input logic signed [15:0] v);
		if (v > COEF_MAX)
		begin
			return COEF_MAX;
		end
		if (v < COEF_MIN)
		begin
			return COEF_MIN;
		end
		return v;
	endfunction

	// ----------------------------------------
	// per input datapath
	// ----------------------------------------
	for (genvar k = 0; k < NCH; k++)
	begin : g_ch
		logic signed [33:0] raw_x;
		logic signed [33:0] cur_x;
		logic signed [33:0] diff;
		logic signed [33:0] prod;
		logic signed [33:0] den_x;
		logic signed [33:0] simple_scaling_x;
		// current range: code at 20 mA maps to full scale
		assign raw_x = 34'($signed(raw[k]));
		assign cur_x = (raw_x * 34'sd10000) / 34'($signed(CUR_FULL_CODE));
		assign eval[k] = q.sel[k] ? sat16(cur_x) : raw[k];
		assign diff = 34'($signed(eval[k])) - 34'($signed(q.off[k]));
		assign prod = diff * 34'($signed(q.num[k]));
		assign den_x = 34'($signed(q.den[k]));
		// simple mode strips the 4 mA live zero on current inputs only
		assign simple_scaling_x = q.sel[k]
			? ((34'($signed(eval[k])) - 34'($signed(LIVE_ZERO))) * 34'($signed(FULL_SCALE)))
				/ 34'($signed(LIVE_SPAN))
			: 34'($signed(eval[k]));
		// zero denominator gives zero rather than an undefined quotient
		// one continuous driver per element keeps result single-driven
		assign result[k] = (q.input_scaling_mode_select == equation_scaling)
			? ((den_x == 34'sd0) ? 16'h0000 : sat16(prod / den_x))
			: sat16(simple_scaling_x);
	end

	// ----------------------------------------
	// register port and result capture
	// ----------------------------------------
	always_comb
	begin
		logic [1:0] fld;
		logic [5:0] rel;
		logic [1:0] ch;
		next_q = q;
		rel = addr - REG_CH_BASE;
		ch = rel[3:2];
		fld = rel[1:0];
		next_q.rdata = 32'h0000_0000;
		// writes: coefficient sets are independent per input
		if (wr)
		begin
			if (addr == REG_MODE)
			begin
				next_q.input_scaling_mode_select = input_scaling_mode_e'(wdata[MODE_BIT]);
			end
			else if (addr >= REG_CH_BASE && addr < REG_SCALED_BASE && ch != 2'd3)
			begin
				case (fld)
					FLD_NUM: next_q.num[ch] = clamp_coef(wdata[15:0]);
					FLD_DEN: next_q.den[ch] = clamp_coef(wdata[15:0]);
					FLD_OFF: next_q.off[ch] = clamp_coef(wdata[15:0]);
					FLD_SEL: next_q.sel[ch] = wdata[SEL_BIT];
					default: next_q.sel[ch] = q.sel[ch];
				endcase
			end
		end
		// reads: coefficients sign extended, unmapped reads return zero
		if (rd)
		begin
			if (addr == REG_MODE)
			begin
				next_q.rdata = {31'h0000_0000, q.input_scaling_mode_select};
			end
			else if (addr >= REG_CH_BASE && addr < REG_SCALED_BASE && ch != 2'd3)
			begin
				case (fld)
					FLD_NUM: next_q.rdata = 32'($signed(q.num[ch]));
					FLD_DEN: next_q.rdata = 32'($signed(q.den[ch]));
					FLD_OFF: next_q.rdata = 32'($signed(q.off[ch]));
					FLD_SEL: next_q.rdata = {31'h0000_0000, q.sel[ch]};
					default: next_q.rdata = 32'h0000_0000;
				endcase
			end
			else if (addr >= REG_SCALED_BASE && addr < REG_SCALED_BASE + 6'd3)
			begin
				next_q.rdata = 32'($signed(q.scaled[2'(addr - REG_SCALED_BASE)]));
			end
		end
		// results hold between samples
		next_q.valid = sample_valid;
		if (sample_valid)
		begin
			next_q.scaled = result;
		end
	end

	// reset loads the default parameter set
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q.input_scaling_mode_select <= simple_scaling;
			q.num <= {NCH{NUM_RESET}};
			q.den <= {NCH{DEN_RESET}};
			q.off <= {NCH{OFF_RESET}};
			q.sel <= '0;
			q.scaled <= '0;
			q.valid <= 1'b0;
			q.rdata <= 32'h0000_0000;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign rdata = q.rdata;
	assign scaled_valid = q.valid;
	assign scaled_demand = q.scaled[0];
	assign scaled_feedback = q.scaled[1];
	assign scaled_speed = q.scaled[2];
	assign current_sense_en = q.sel;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_mode_hold;
		!(wr && addr == REG_MODE) |=> $stable(q.input_scaling_mode_select);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed without a write");

	property p_eq_identity;
		sample_valid && q.input_scaling_mode_select == equation_scaling && !q.sel[0]
			&& q.off[0] == 16'h0000 && q.num[0] == q.den[0] && q.den[0] != 16'h0000
			&& !wr
		|=> scaled_demand == $past(raw_demand);
	endproperty
	a_eq_identity: assert property (p_eq_identity) else $error("unity gain altered input");

	property p_coef_range;
		$signed(q.num[1]) <= COEF_MAX && $signed(q.den[2]) >= COEF_MIN;
	endproperty
	a_coef_range: assert property (p_coef_range) else $error("coefficient out of range");

	property p_offset_only;
		sample_valid && q.input_scaling_mode_select == equation_scaling && !q.sel[1]
			&& q.num[1] == q.den[1] && q.den[1] != 16'h0000 && !wr
			&& $signed(raw_feedback) == $signed(q.off[1])
		|=> scaled_feedback == 16'h0000;
	endproperty
	a_offset_only: assert property (p_offset_only) else $error("offset not removed");

	property p_sel_pin;
		wr && addr == REG_CH_BASE + {FLD_SEL[1], FLD_SEL[0]}
			|=> current_sense_en[0] == $past(wdata[SEL_BIT]);
	endproperty
	a_sel_pin: assert property (p_sel_pin) else $error("sense resistor not switched");

	property p_live_zero;
		sample_valid && q.input_scaling_mode_select == equation_scaling && q.sel[1]
			&& q.off[1] == LIVE_ZERO && q.num[1] == 16'h04E2 && q.den[1] == 16'h03E8
			&& raw_feedback == CUR_FULL_CODE && !wr
		|=> scaled_feedback == FULL_SCALE;
	endproperty
	a_live_zero: assert property (p_live_zero) else $error("20 mA not full scale");

	property p_latency;
		sample_valid |=> scaled_valid ##1 (scaled_valid == $past(sample_valid));
	endproperty
	a_latency: assert property (p_latency) else $error("result valid not one cycle after sample");

	property p_hold;
		!sample_valid |=> $stable(scaled_demand) && $stable(scaled_speed) && !scaled_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("result moved without a sample");

	property p_saturate;
		sample_valid && q.input_scaling_mode_select == equation_scaling && !q.sel[1]
			&& q.off[1] == COEF_MIN && q.num[1] == COEF_MAX && q.den[1] == 16'h0001
			&& !raw_feedback[15] && !wr
		|=> scaled_feedback == 16'h7FFF;
	endproperty
	a_saturate: assert property (p_saturate) else $error("result wrapped instead of saturating");

	property p_rdata_idle;
		!rd |=> rdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");

	c_equation: cover property (q.input_scaling_mode_select == equation_scaling && sample_valid);
	c_current: cover property (sample_valid && q.sel[0] && q.sel[2]);
	c_sat: cover property (scaled_valid && scaled_feedback == 16'h7FFF);
	c_back_to_back: cover property (wr ##1 rd ##1 sample_valid);
endmodule // analog_input_linear_scaler

// *** pkg/scaler_pkg.sv ***
// Purpose: constants shared by the analog input scaler
// Assumes: register port is word indexed, one index per register
// Notes: all values are in 0.01 % of full scale unless stated
package scaler_pkg;
	// ----------------------------------------
	// register indices
	// ----------------------------------------
	localparam logic [5:0] REG_MODE = 6'h00;
	localparam logic [5:0] REG_CH_BASE = 6'h04;
	localparam logic [5:0] REG_SCALED_BASE = 6'h10;
	localparam logic [1:0] FLD_NUM = 2'h0;
	localparam logic [1:0] FLD_DEN = 2'h1;
	localparam logic [1:0] FLD_OFF = 2'h2;
	localparam logic [1:0] FLD_SEL = 2'h3;
	// ----------------------------------------
	// field positions and widths
	// ----------------------------------------
	localparam int MODE_BIT = 0;
	localparam int SEL_BIT = 0;
	localparam int NCH = 3;
	// ----------------------------------------
	// value ranges and reset values
	// ----------------------------------------
	localparam logic signed [15:0] COEF_MAX = 16'sh2710;
	localparam logic signed [15:0] COEF_MIN = -16'sh2710;
	localparam logic signed [15:0] FULL_SCALE = 16'sh2710;
	localparam logic signed [15:0] NUM_RESET = 16'sh03E8;
	localparam logic signed [15:0] DEN_RESET = 16'sh03E8;
	localparam logic signed [15:0] OFF_RESET = 16'sh0000;
	localparam logic signed [15:0] LIVE_ZERO = 16'sh07D0;
	localparam logic signed [15:0] LIVE_SPAN = 16'sh1F40;
	// raw code seen at 20 mA across the sense resistor
	localparam logic signed [15:0] CUR_FULL_CODE = 16'sh1388;
	typedef enum logic [0:0] {
		simple_scaling = 1'b0,
		equation_scaling = 1'b1
	} input_scaling_mode_e;
	typedef enum logic [0:0] {
		eval_voltage = 1'b0,
		eval_current = 1'b1
	} eval_sel_e;
endpackage

// *** verif/analog_sources.sv ***
// Purpose: stands in for the demand, feedback and speed sources
// Assumes: a go cycle gives one sample on the next cycle
// Notes: idle codes invert each cycle so stale data never look valid
`timescale 1ns/100ps
module analog_sources
(
	input wire logic clk,
	input wire logic go,
	input wire logic [47:0] vals,
	output logic sample_valid,
	output logic signed [15:0] raw_demand,
	output logic signed [15:0] raw_feedback,
	output logic signed [15:0] raw_speed
);
	// ----------------------------------------
	// sample launch
	// ----------------------------------------
	// known start so the inversion below never feeds unknowns
	initial
	begin
		sample_valid = 1'b0;
		{raw_speed, raw_feedback, raw_demand} = 48'h0000_0000_0000;
	end
	// no hold after a sample: the lines move on at once
	always @(posedge clk)
	begin
		sample_valid <= go;
		{raw_speed, raw_feedback, raw_demand} <= go ? vals : ~{raw_speed, raw_feedback, raw_demand};
	end
endmodule // analog_sources

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the analog input scaler
// Assumes: no wait states on the register port, sample latency one cycle
// Notes: expected codes come from a bench model of the scaling equation_scaling
`timescale 1ns/100ps
module testbench import scaler_pkg::*;;
	logic clk = 0, rst = 1, wr = 0, rd = 0, go = 0, rd_q = 0;
	logic [5:0] addr = 6'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [47:0] vals = 48'h0000_0000_0000;
	logic [31:0] rdata;
	logic [2:0] current_sense_en;
	logic sample_valid, scaled_valid;
	logic signed [15:0] raw_demand, raw_feedback, raw_speed;
	logic signed [15:0] scaled_demand, scaled_feedback, scaled_speed;
	int bad_count = 0, check_count = 0, cyc = 0, seed = 76666, mode = 0;
	int num[3] = '{1000, 1000, 1000}, den[3] = '{1000, 1000, 1000};
	int off[3] = '{0, 0, 0}, sel[3] = '{0, 0, 0};
	logic [31:0] rq[$];
	logic [47:0] sq[$];
	logic [47:0] last_exp = 48'h0000_0000_0000;
	// ----------------------------------------
	// parts under test
	// ----------------------------------------
	analog_sources i_analog_sources (.clk, .go, .vals, .sample_valid, .raw_demand,
		.raw_feedback, .raw_speed);
	analog_input_linear_scaler i_analog_input_linear_scaler (.clk, .rst, .addr, .wdata,
		.wr, .rd, .rdata, .sample_valid, .raw_demand, .raw_feedback, .raw_speed,
		.scaled_valid, .scaled_demand, .scaled_feedback, .scaled_speed, .current_sense_en);
	// 200 MHz clock
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	// ----------------------------------------
	// model and helpers
	// ----------------------------------------
	function automatic longint clp(longint v, longint lo, longint hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction
	// one input through the documented equation_scaling, saturating to 16 bits
	function automatic logic [15:0] one(int k, longint r);
		longint e;
		e = sel[k] ? clp(r * FULL_SCALE / CUR_FULL_CODE, -32768, 32767) : r;
		if (mode == 1)
			e = den[k] == 0 ? 0 : clp((e - off[k]) * num[k] / den[k], -32768, 32767);
		else if (sel[k] == 1)
			e = clp((e - LIVE_ZERO) * FULL_SCALE / LIVE_SPAN, -32768, 32767);
		return e[15:0];
	endfunction
	function automatic logic [47:0] expv(logic [47:0] x);
		return {one(2, $signed(x[47:32])), one(1, $signed(x[31:16])), one(0, $signed(x[15:0]))};
	endfunction
	task automatic chk(string nm, logic [47:0] e, logic [47:0] s);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask
	// a free cycle after each strobe keeps one assignment per time step
	task automatic wreg(logic [5:0] a, int v);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(logic [5:0] a, logic [31:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		rq.push_back(e);
		@(posedge clk);
		rd <= 0;
	endtask
	// coefficients are clamped on write, so the model clamps too
	task automatic cfg(int k, int n, int d, int o, int s);
		logic [5:0] b;
		b = REG_CH_BASE + 6'(4 * k);
		num[k] = int'(clp(n, -10000, 10000));
		den[k] = int'(clp(d, -10000, 10000));
		off[k] = int'(clp(o, -10000, 10000));
		sel[k] = s;
		wreg(b, n);
		wreg(b + 6'h01, d);
		wreg(b + 6'h02, o);
		wreg(b + 6'h03, s);
		rreg(b, num[k]);
		rreg(b + 6'h02, off[k]);
	endtask
	// n above one draws random codes inside the input range
	task automatic run(int n, logic [47:0] v);
		logic [47:0] x;
		for (int i = 0; i < n; i++)
		begin
			x = v;
			if (n > 1)
				x = {16'($random(seed) % 10001), 16'($random(seed) % 10001),
					16'($random(seed) % 10001)};
			@(posedge clk);
			go <= 1;
			vals <= x;
			last_exp = expv(x);
			sq.push_back(last_exp);
		end
		@(posedge clk);
		go <= 0;
		repeat (3) @(posedge clk);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// monitor and watchdog
	// ----------------------------------------
	always @(posedge clk)
		rd_q <= rd;
	// mid-cycle look, clear of the edge that launched the result
	always @(negedge clk)
	begin
		if (rd_q)
			chk("rdata", rq.pop_front(), rdata);
		if (scaled_valid === 1'b1)
			chk("scaled", sq.size() ? sq.pop_front() : 'x,
				{scaled_speed, scaled_feedback, scaled_demand});
	end
	// run needs a few hundred cycles, so this only trips on a hang
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			test_done();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 0;
		rreg(REG_MODE, 0);
		rreg(REG_CH_BASE + 6'h01, 1000);
		chk("sense", 0, current_sense_en);
		run(5, 0);
		cfg(1, 1000, 1000, 0, 1);
		chk("sense", 2, current_sense_en);
		run(1, 48'h0000_03E8_0000);
		run(1, 48'h0000_1388_0000);
		mode = 1;
		wreg(REG_MODE, 1);
		run(3, 0);
		cfg(0, 2345, 1000, -500, 0);
		cfg(1, 1250, 1000, 2000, 1);
		cfg(2, -800, 300, 1000, 1);
		chk("sense", 6, current_sense_en);
		run(1, 48'h0000_1388_0000);
		run(8, 0);
		cfg(1, -700, -700, 1234, 0);
		run(1, 48'h0000_04D2_0000);
		cfg(0, 20000, -20000, 30000, 0);
		cfg(1, 10000, 1, -10000, 0);
		cfg(2, 1000, 0, 0, 1);
		run(6, 0);
		rreg(REG_SCALED_BASE + 6'h01, 32'($signed(last_exp[31:16])));
		wreg(6'h3F, 32'h0000_1234);
		rreg(6'h3F, 0);
		rreg(REG_MODE, 1);
		mode = 0;
		wreg(REG_MODE, 0);
		cfg(0, 1000, 1000, 0, 1);
		chk("sense", 5, current_sense_en);
		run(4, 0);
		chk("pending", 0, 48'(sq.size() + rq.size()));
		test_done();
	end
endmodule // testbench
